// File: rtl/gteb_pkg.sv
// ----------------------------------------------------------------------------
// gteb_pkg: shared constants and types for the gmii transmit elastic buffer
// ----------------------------------------------------------------------------
// holds widths, fifo geometry, fill thresholds and the gmii word carrier.
// assumes every design file refers to these as gteb_pkg::name.
package gteb_pkg;

    // ------------------------------------------------------------------------
    // geometry and fill thresholds
    // ------------------------------------------------------------------------
    localparam int GTEB_DATA_W = 8;
    localparam int GTEB_ADDR_W = 4;                 // 16 entries of storage
    localparam int GTEB_LVL_W = GTEB_ADDR_W + 1;
    localparam logic [GTEB_LVL_W-1:0] GTEB_LVL_TARGET = 5'h08;
    localparam logic [GTEB_LVL_W-1:0] GTEB_LVL_HIGH = 5'h0C;
    localparam logic [GTEB_LVL_W-1:0] GTEB_LVL_LOW = 5'h04;
    localparam logic [GTEB_LVL_W-1:0] GTEB_LVL_PAIR = 5'h02;

    // ------------------------------------------------------------------------
    // timing: core clock rate, used for one byte per cycle on the core side
    // ------------------------------------------------------------------------
    localparam int GTEB_CORE_CLK_MHZ = 125;

    // ------------------------------------------------------------------------
    // one gmii transmit column: enable, error, data
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic en;
        logic er;
        logic [GTEB_DATA_W-1:0] d;
    } gteb_gmii_t;

    localparam int GTEB_WORD_W = GTEB_DATA_W + 2;
    localparam gteb_gmii_t GTEB_IDLE = '{en: 1'b0, er: 1'b0, d: 8'h00};
    localparam gteb_gmii_t GTEB_UNDERRUN_WORD = '{en: 1'b1, er: 1'b1, d: 8'h00};

    // ------------------------------------------------------------------------
    // read side states
    // ------------------------------------------------------------------------
    typedef enum logic [0:0] {
        GTEB_FILL,
        GTEB_RUN
    } gteb_state_t;

endpackage

// File: rtl/gteb_fifo.sv
// ----------------------------------------------------------------------------
// gteb_fifo: small distributed-memory fifo with two-word peek
// ----------------------------------------------------------------------------
// holds the storage array and pointers of the elastic buffer.
// assumes the caller never pushes when full and never pops more than level.
`timescale 1ns/1ns
`default_nettype none

module gteb_fifo #(
    parameter int ADDR_W = gteb_pkg::GTEB_ADDR_W
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // write side
    input wire logic push,
    input wire gteb_pkg::gteb_gmii_t wr_word,
    // read side: pop 0, 1 or 2 words per cycle
    input wire logic [1:0] pop_cnt,
    output gteb_pkg::gteb_gmii_t head_word,
    output gteb_pkg::gteb_gmii_t next_word,
    // occupancy
    output logic [ADDR_W:0] level,
    output logic full
);

    gteb_pkg::gteb_gmii_t mem [0:(1<<ADDR_W)-1];
    logic [ADDR_W:0] wr_ptr_r;
    logic [ADDR_W:0] rd_ptr_r;
    logic [ADDR_W-1:0] rd_next_addr;

    // ------------------------------------------------------------------------
    // storage: no reset, so it maps to distributed memory
    // ------------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_r[ADDR_W-1:0]] <= wr_word;
        end
    end

    // write pointer
    always_ff @(posedge clock) begin
        if (rst) begin
            wr_ptr_r <= '0;
        end else if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
        end
    end

    // read pointer advances by the number of words consumed
    always_ff @(posedge clock) begin
        if (rst) begin
            rd_ptr_r <= '0;
        end else begin
            rd_ptr_r <= rd_ptr_r + {{(ADDR_W-1){1'b0}}, pop_cnt};
        end
    end

    // asynchronous peek of the two oldest words
    assign rd_next_addr = rd_ptr_r[ADDR_W-1:0] + 1'b1;
    assign head_word = mem[rd_ptr_r[ADDR_W-1:0]];
    assign next_word = mem[rd_next_addr];
    assign level = wr_ptr_r - rd_ptr_r;
    assign full = level[ADDR_W];

endmodule // gteb_fifo

`default_nettype wire

// File: rtl/gteb_tx_elastic.sv
// ----------------------------------------------------------------------------
// gteb_tx_elastic: gmii transmit elastic buffer into the core clock domain
// ----------------------------------------------------------------------------
// holds the link sampling, the fifo instance and the idle add/drop reader.
// assumes the mac transmit clock is much slower than clock, so that every
// high and low phase is seen by at least two core samples.
// assumes nothing downstream stalls: the core takes a column every cycle.
// a mac far slower than the core forces mid-frame underruns; they are marked, not hidden.
`timescale 1ns/1ns
`default_nettype none

module gteb_tx_elastic #(
    parameter int ADDR_W = gteb_pkg::GTEB_ADDR_W
) (
    // core clock and reset
    input wire logic clock,
    input wire logic rst,
    // gmii transmit pins from the remote mac
    input wire logic gmii_tx_clk,
    input wire logic gmii_tx_en,
    input wire logic gmii_tx_er,
    input wire logic [gteb_pkg::GTEB_DATA_W-1:0] gmii_txd,
    // core side column, one per cycle
    output gteb_pkg::gteb_gmii_t core_tx,
    // status pulses and occupancy
    output logic underrun_pulse,
    output logic overrun_pulse,
    output logic idle_added_pulse,
    output logic idle_dropped_pulse,
    output logic [ADDR_W:0] fill_level
);

    // ------------------------------------------------------------------------
    // link sampling
    // ------------------------------------------------------------------------
    logic clk_meta_r;
    logic clk_sync_r;
    logic clk_prev_r;
    gteb_pkg::gteb_gmii_t pin_word;
    gteb_pkg::gteb_gmii_t pin_meta_r;
    gteb_pkg::gteb_gmii_t pin_sync_r;
    gteb_pkg::gteb_gmii_t pin_prev_r;
    logic link_rise;

    assign pin_word = '{en: gmii_tx_en, er: gmii_tx_er, d: gmii_txd};

    // two-flop synchronisers; first stage feeds only the second.
    // the clock pipe resets high: a mac clock already high at release must
    // not look like a fresh rise, or the reset idle word would be pushed as a column
    always_ff @(posedge clock) begin
        if (rst) begin
            clk_meta_r <= 1'b1;
            clk_sync_r <= 1'b1;
            clk_prev_r <= 1'b1;
        end else begin
            clk_meta_r <= gmii_tx_clk;
            clk_sync_r <= clk_meta_r;
            clk_prev_r <= clk_sync_r;
        end
    end

    // data rides the same pipe so it stays aligned with the sampled clock
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_meta_r <= gteb_pkg::GTEB_IDLE;
            pin_sync_r <= gteb_pkg::GTEB_IDLE;
            pin_prev_r <= gteb_pkg::GTEB_IDLE;
        end else begin
            pin_meta_r <= pin_word;
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
        end
    end

    // rising edge of the mac clock; the word taken is the one sampled while
    // the clock was still low, since the mac may change data at that edge
    assign link_rise = clk_sync_r & ~clk_prev_r;

    // ------------------------------------------------------------------------
    // fifo
    // ------------------------------------------------------------------------
    gteb_pkg::gteb_gmii_t head_word;
    gteb_pkg::gteb_gmii_t next_word;
    logic [ADDR_W:0] level;
    logic full;
    logic push;
    logic [1:0] pop_cnt;

    // a push into a full buffer is dropped and reported
    assign push = link_rise & ~full;

    gteb_fifo #(
        .ADDR_W(ADDR_W)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .push(push),
        .wr_word(pin_prev_r),
        .pop_cnt(pop_cnt),
        .head_word(head_word),
        .next_word(next_word),
        .level(level),
        .full(full)
    );

    // ------------------------------------------------------------------------
    // read side: idle add / drop
    // ------------------------------------------------------------------------
    gteb_pkg::gteb_state_t state_r;
    gteb_pkg::gteb_state_t state_nxt;
    gteb_pkg::gteb_gmii_t out_nxt;
    logic in_frame;
    logic head_idle;
    logic next_idle;
    logic underrun_nxt;
    logic added_nxt;
    logic dropped_nxt;

    // the last column sent tells whether a frame is passing through;
    // the buffer cannot see a frame's end before the next column arrives,
    // so an empty buffer right after a last byte is treated as mid-frame
    assign in_frame = core_tx.en;
    // carrier extension (er without en) is not idle and is never touched
    assign head_idle = ~head_word.en & ~head_word.er;
    assign next_idle = ~next_word.en & ~next_word.er;

    // choose this cycle's column; exactly one leaves every cycle
    always_comb begin
        state_nxt = state_r;
        out_nxt = gteb_pkg::GTEB_IDLE;
        pop_cnt = 2'd0;
        underrun_nxt = 1'b0;
        added_nxt = 1'b0;
        dropped_nxt = 1'b0;
        case (state_r)
            gteb_pkg::GTEB_FILL: begin
                // wait for the target level, sending idle meanwhile
                if (level >= {1'b0, gteb_pkg::GTEB_LVL_TARGET[ADDR_W-1:0]}) begin
                    state_nxt = gteb_pkg::GTEB_RUN;
                end
            end
            gteb_pkg::GTEB_RUN: begin
                if (level == '0) begin
                    // empty: mid-frame this cannot be hidden, so mark it
                    // (a frame that just ended with the buffer empty is marked too)
                    if (in_frame) begin
                        out_nxt = gteb_pkg::GTEB_UNDERRUN_WORD;
                        underrun_nxt = 1'b1;
                    end
                    state_nxt = gteb_pkg::GTEB_FILL;
                end else if (!in_frame && head_idle
                             && level < gteb_pkg::GTEB_LVL_LOW) begin
                    // repeat an idle: hold the head, send idle
                    added_nxt = 1'b1;
                end else if (!in_frame && head_idle && next_idle
                             && level > gteb_pkg::GTEB_LVL_HIGH
                             && level >= gteb_pkg::GTEB_LVL_PAIR) begin
                    // drop an idle: consume two idles, send one
                    // only reachable when the mac runs at least as fast as the core
                    pop_cnt = 2'd2;
                    dropped_nxt = 1'b1;
                end else begin
                    // frame columns always pass one for one, in order
                    out_nxt = head_word;
                    pop_cnt = 2'd1;
                end
            end
            default: begin
                state_nxt = gteb_pkg::GTEB_FILL;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // registered state and outputs
    // ------------------------------------------------------------------------

    // read state
    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= gteb_pkg::GTEB_FILL;
        end else begin
            state_r <= state_nxt;
        end
    end

    // core side column, registered
    always_ff @(posedge clock) begin
        if (rst) begin
            core_tx <= gteb_pkg::GTEB_IDLE;
        end else begin
            core_tx <= out_nxt;
        end
    end

    // status pulses and occupancy, registered
    always_ff @(posedge clock) begin
        if (rst) begin
            underrun_pulse <= 1'b0;
            overrun_pulse <= 1'b0;
            idle_added_pulse <= 1'b0;
            idle_dropped_pulse <= 1'b0;
            fill_level <= '0;
        end else begin
            underrun_pulse <= underrun_nxt;
            overrun_pulse <= link_rise & full;
            idle_added_pulse <= added_nxt;
            idle_dropped_pulse <= dropped_nxt;
            fill_level <= level;
        end
    end

endmodule // gteb_tx_elastic

`default_nettype wire

// File: testbench/gteb_tx_elastic_asserts.sv
// port checks for the gmii transmit elastic buffer
// assumes a bind onto gteb_tx_elastic and a single core clock domain
`timescale 1ns/1ns
`default_nettype none
module gteb_tx_elastic_chk #(
    parameter int ADDR_W = gteb_pkg::GTEB_ADDR_W
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // gmii pins
    input wire logic gmii_tx_clk,
    input wire logic gmii_tx_en,
    input wire logic gmii_tx_er,
    input wire logic [gteb_pkg::GTEB_DATA_W-1:0] gmii_txd,
    // core side
    input wire gteb_pkg::gteb_gmii_t core_tx,
    input wire logic underrun_pulse,
    input wire logic overrun_pulse,
    input wire logic idle_added_pulse,
    input wire logic idle_dropped_pulse,
    input wire logic [ADDR_W:0] fill_level
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // refill after reset or underrun needs eight slow mac columns
    sequence s_quiet;
        (!core_tx.en) [*8];
    endsequence
    // an idle that follows a column without en, so no frame is touched
    sequence s_idle_out;
        !core_tx.en && !core_tx.er && !$past(core_tx.en);
    endsequence
    property p_fill_first;
        $fell(rst) |-> s_quiet;
    endproperty
    property p_underrun_mark;
        underrun_pulse |-> core_tx == gteb_pkg::GTEB_UNDERRUN_WORD && $past(core_tx.en);
    endproperty
    property p_refill;
        underrun_pulse |=> s_quiet;
    endproperty
    property p_add;
        idle_added_pulse |-> s_idle_out ##0 fill_level < gteb_pkg::GTEB_LVL_LOW;
    endproperty
    property p_drop;
        idle_dropped_pulse |-> s_idle_out ##0 fill_level > gteb_pkg::GTEB_LVL_HIGH;
    endproperty
    // one push and at most two pops per cycle
    property p_level_step;
        fill_level <= $past(fill_level) + 1 && fill_level + 2 >= $past(fill_level);
    endproperty
    property p_excl;
        !(idle_added_pulse && (idle_dropped_pulse || underrun_pulse));
    endproperty
    property p_sent_filled;
        core_tx.en && !underrun_pulse |-> fill_level != 0;
    endproperty
    a_fill_first: assert property (p_fill_first) else $error("frame column during fill");
    a_underrun_mark: assert property (p_underrun_mark) else $error("bad underrun column");
    a_refill: assert property (p_refill) else $error("no refill after underrun");
    a_add: assert property (p_add) else $error("idle added wrongly");
    a_drop: assert property (p_drop) else $error("idle dropped wrongly");
    a_level_step: assert property (p_level_step) else $error("fill level jump");
    a_excl: assert property (p_excl) else $error("pulses overlap");
    a_sent_filled: assert property (p_sent_filled) else $error("byte from empty fifo");
endmodule // gteb_tx_elastic_chk
`default_nettype wire

// File: testbench/gteb_mac_model.sv
// remote mac: drives gmii transmit columns on its own 64 ns clock
// assumes the bench reads sent_q by hierarchy and done through its port
`timescale 1ns/1ns
`default_nettype none
module gteb_mac_model (
    // gmii transmit pins
    output logic gmii_tx_clk,
    output logic gmii_tx_en,
    output logic gmii_tx_er,
    output logic [gteb_pkg::GTEB_DATA_W-1:0] gmii_txd,
    // script finished
    output logic done
);
    gteb_pkg::gteb_gmii_t sent_q[$];
    logic [15:0] lfsr_r;
    function automatic logic [15:0] lfsr_step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // own free-running source, every edge 1 ns before a core rising edge
    initial begin
        gmii_tx_clk = 1'b0;
        #3;
        forever #32 gmii_tx_clk = ~gmii_tx_clk;
    end
    // change mid-cycle so pins are steady around each rising edge
    task automatic put(input logic en, input logic er);
        @(negedge gmii_tx_clk);
        lfsr_r = lfsr_step(lfsr_r);
        gmii_tx_en <= en;
        gmii_tx_er <= er;
        gmii_txd <= lfsr_r[15:8]; // idle data is random too
        if (en) sent_q.push_back(gteb_pkg::gteb_gmii_t'({en, er, lfsr_r[15:8]}));
    endtask
    // random short frames, one long frame and one long gap
    initial begin
        int len;
        int gap;
        gmii_tx_en = 1'b0;
        gmii_tx_er = 1'b0;
        gmii_txd = 8'h00;
        done = 1'b0;
        lfsr_r = 16'hDC43;
        for (int k = 0; k < 14; k++) begin
            len = (k == 5) ? 24 : 1 + int'(lfsr_r[1:0]);
            gap = (k == 8) ? 40 : (k == 0) ? 12 : 3 + int'(lfsr_r[4:2]);
            repeat (gap) put(1'b0, 1'b0);
            repeat (len) put(1'b1, &lfsr_r[3:0]);
        end
        repeat (20) put(1'b0, 1'b0);
        done = 1'b1;
        forever put(1'b0, 1'b0);
    end
endmodule // gteb_mac_model
`default_nettype wire

// File: testbench/gteb_tx_elastic_test.sv
// self-checking bench for the gmii transmit elastic buffer
// assumes gteb_mac_model on the far side and the checker bound below
`timescale 1ns/1ns
`default_nettype none
module gteb_tx_elastic_test;
    logic clock;
    logic rst;
    logic gmii_tx_clk;
    logic gmii_tx_en;
    logic gmii_tx_er;
    logic [7:0] gmii_txd;
    logic done;
    gteb_pkg::gteb_gmii_t core_tx;
    logic underrun_pulse;
    logic overrun_pulse;
    logic idle_added_pulse;
    logic idle_dropped_pulse;
    logic [gteb_pkg::GTEB_ADDR_W:0] fill_level;
    int fails = 0;
    int checks = 0;
    int underruns = 0;
    int adds = 0;
    gteb_pkg::gteb_gmii_t exp_col;
    gteb_mac_model u_gteb_mac_model (.gmii_tx_clk(gmii_tx_clk), .gmii_tx_en(gmii_tx_en),
        .gmii_tx_er(gmii_tx_er), .gmii_txd(gmii_txd), .done(done));
    gteb_tx_elastic u_gteb_tx_elastic (.clock(clock), .rst(rst), .gmii_tx_clk(gmii_tx_clk),
        .gmii_tx_en(gmii_tx_en), .gmii_tx_er(gmii_tx_er), .gmii_txd(gmii_txd),
        .core_tx(core_tx), .underrun_pulse(underrun_pulse), .overrun_pulse(overrun_pulse),
        .idle_added_pulse(idle_added_pulse), .idle_dropped_pulse(idle_dropped_pulse),
        .fill_level(fill_level));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d fails %0d underruns %0d", checks, fails, underruns);
        if (fails == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // reset state: idle column, nothing stored, no pulses
    task automatic rst_look();
        @(negedge clock);
        check("rst_col", {22'h0, core_tx}, {22'h0, gteb_pkg::GTEB_IDLE});
        check("rst_fill", {27'h0, fill_level}, 32'h0000_0000);
        check("rst_pulse", {28'h0, underrun_pulse, overrun_pulse, idle_added_pulse,
            idle_dropped_pulse}, 32'h0000_0000);
    endtask
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // settled outputs: every frame column except an underrun mark must match what the mac sent, in order
    always @(negedge clock) begin
        if (!rst && idle_added_pulse === 1'b1) adds++;
        if (!rst && core_tx.en === 1'b1 && underrun_pulse === 1'b1) underruns++;
        else if (!rst && core_tx.en === 1'b1 && u_gteb_mac_model.sent_q.size() == 0)
            check("extra_col", {22'h0, core_tx}, 32'h0000_0000);
        else if (!rst && core_tx.en === 1'b1) begin
            exp_col = u_gteb_mac_model.sent_q.pop_front();
            check("frame_col", {22'h0, core_tx}, {22'h0, exp_col});
        end
    end
    initial begin
        rst = 1'b1;
        repeat (4) @(posedge clock);
        rst_look();
        @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 20000 && done !== 1'b1; i++) @(posedge clock);
        check("script_done", {31'h0, done}, 32'h0000_0001);
        for (int i = 0; i < 4000 && u_gteb_mac_model.sent_q.size() != 0; i++) @(posedge clock);
        check("left_over", u_gteb_mac_model.sent_q.size(), 32'h0000_0000);
        check("underrun_seen", underruns > 0, 32'h0000_0001);
        check("idle_add_seen", adds > 0, 32'h0000_0001);
        // second reset in mid-run must flush the buffer
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst_look();
        @(posedge clock);
        rst <= 1'b0;
        repeat (100) @(posedge clock);
        close_out();
    end
    // watchdog: the script needs roughly 13 us
    initial begin
        #300000;
        fails++;
        close_out();
    end
endmodule // gteb_tx_elastic_test
bind gteb_tx_elastic gteb_tx_elastic_chk #(.ADDR_W(ADDR_W)) u_gteb_tx_elastic_chk (
    .clock(clock), .rst(rst), .gmii_tx_clk(gmii_tx_clk), .gmii_tx_en(gmii_tx_en),
    .gmii_tx_er(gmii_tx_er), .gmii_txd(gmii_txd), .core_tx(core_tx),
    .underrun_pulse(underrun_pulse), .overrun_pulse(overrun_pulse),
    .idle_added_pulse(idle_added_pulse), .idle_dropped_pulse(idle_dropped_pulse),
    .fill_level(fill_level));
`default_nettype wire
